// *** rtl/ppp_dev.sv ***
// Behaviour
// - host toggles load clock six times first
// - host holds entry pins low 100ns
// - entry pin change within 100ns refuses mode
// - host waits 50us before first command
// - load clock pulse acts per action select
// - decode write command bytes
// - decode read command bytes
// - no-op command ends page programming
// - command and address kept across operations
// - host reloads high address per window
// - erase clears flash, eeprom, lock last
// - keep-eeprom fuse preserves eeprom on erase
// - host erases before reprogramming
// - write strobe starts erase, busy low
// - flash data buffered, page programmed once
// - half select picks low or high byte
// - page latch stores word into buffer
// - low bits word, high bits page
// - write strobe programs page, busy low
// - drive data only while output enable low
`timescale 1ns/10ps
module ppp_dev
	import ppp_pkg::*;
(
	// clock and reset
	input  wire logic MCLK,
	input  wire logic RST,
	// link
	ppp_if.dev        LNK,
	// fuse state
	input  wire logic KEEP_EEPROM_FUSE,
	// status
	output logic      PROG_MODE,
	output logic [7:0] LOCK_BITS
);
	typedef enum {PPP_OFF, PPP_SETTLE, PPP_ACTIVE, PPP_ERASE, PPP_PROG} ppp_state_t;

	// ------------------------------------------------------------
	// synchronisers and edge detection
	// ------------------------------------------------------------
	logic [5:0] s1_r, s2_r, s3_r;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s1_r <= 6'h08;                                  // idle levels, strobe high
			s2_r <= 6'h08;
			s3_r <= 6'h08;
		end else begin
			s1_r <= {LNK.hv_reset, LNK.load_clock_pin, LNK.write_n, LNK.half_select,
				LNK.action_select_high, LNK.action_select_low};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic hv, xrise, wfall, prise;
	logic [3:0] entry_pins;
	assign hv         = s2_r[5];
	assign xrise      = s2_r[4] & ~s3_r[4];
	assign wfall      = ~s2_r[3] & s3_r[3];
	assign prise      = s2_r[2] & ~s3_r[2];              // page latch shares half select
	assign entry_pins = s2_r[3:0];

	// ------------------------------------------------------------
	// memories
	// ------------------------------------------------------------
	logic [15:0] flash [PPP_FLASH_WORDS];
	logic [7:0]  eeprom [PPP_EE_BYTES];
	logic [15:0] pbuf [PPP_PAGE_WORDS];

	function automatic logic is_write_cmd(input logic [7:0] c);
		return c == PPP_CMD_ERASE || c == PPP_CMD_WR_FUSE || c == PPP_CMD_WR_LOCK ||
			c == PPP_CMD_WR_FLASH || c == PPP_CMD_WR_EE;
	endfunction

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	ppp_state_t st_r, st_nxt;
	logic [7:0]  cmd_r, cmd_nxt, alo_r, alo_nxt, ahi_r, ahi_nxt;
	logic [7:0]  dlo_r, dlo_nxt, dhi_r, dhi_nxt, lock_r, lock_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [8:0]  ecnt_r, ecnt_nxt;
	logic        wr_en_r, wr_en_nxt;
	logic [PPP_ADDR_BITS-1:0] addr;
	assign addr = {ahi_r[PPP_ADDR_BITS-9:0], alo_r};

	// fifo carries loaded data bytes into the word assembler
	logic fi_rdy, fo_val, fo_rdy;
	logic [8:0] fo_dat;
	logic fi_val;
	assign fi_val = st_r == PPP_ACTIVE && xrise &&
		{s2_r[1], s2_r[0]} == PPP_ACT_DATA;
	assign fo_rdy = 1'b1;
	ppp_fifo #(.WIDTH(9), .DEPTH(PPP_FIFO_DEPTH)) ppp_fifo_inst (
		.clk       (MCLK),
		.rst       (RST),
		.in_valid  (fi_val),
		.in_ready  (fi_rdy),
		.in_data   ({s2_r[2], LNK.data_bus}),
		.out_valid (fo_val),
		.out_ready (fo_rdy),
		.out_data  (fo_dat)
	);

	// next-state logic
	always_comb begin
		st_nxt    = st_r;
		cmd_nxt   = cmd_r;
		alo_nxt   = alo_r;
		ahi_nxt   = ahi_r;
		dlo_nxt   = dlo_r;
		dhi_nxt   = dhi_r;
		lock_nxt  = lock_r;
		cnt_nxt   = cnt_r;
		ecnt_nxt  = ecnt_r;
		wr_en_nxt = wr_en_r;
		if (fo_val) begin
			if (fo_dat[8]) dhi_nxt = fo_dat[7:0];
			else           dlo_nxt = fo_dat[7:0];
		end
		case (st_r)
			PPP_OFF: begin
				cnt_nxt = '0;
				if (hv && entry_pins == 4'h0) st_nxt = PPP_SETTLE;
			end
			PPP_SETTLE: begin
				if (!hv || entry_pins != 4'h0) begin
					st_nxt = PPP_OFF;
				end else if (cnt_r == 16'(PPP_QUIET_CYC)) begin
					st_nxt = PPP_ACTIVE;
				end else begin
					cnt_nxt = 16'(cnt_r + 1'b1);
				end
			end
			PPP_ACTIVE: begin
				if (xrise) begin
					case ({s2_r[1], s2_r[0]})
						PPP_ACT_CMD: begin
							cmd_nxt   = LNK.data_bus;
							wr_en_nxt = is_write_cmd(LNK.data_bus);
						end
						PPP_ACT_ADDR: begin
							if (s2_r[2]) ahi_nxt = LNK.data_bus;
							else         alo_nxt = LNK.data_bus;
						end
						default: ;
					endcase
				end
				if (wfall && wr_en_r) begin
					cnt_nxt = '0;
					if (cmd_r == PPP_CMD_ERASE) begin
						st_nxt   = PPP_ERASE;
						ecnt_nxt = '0;
					end else if (cmd_r == PPP_CMD_WR_FLASH) begin
						st_nxt = PPP_PROG;
					end else if (cmd_r == PPP_CMD_WR_LOCK) begin
						lock_nxt = lock_r & dlo_r;
					end
				end
			end
			PPP_ERASE: begin
				ecnt_nxt = 9'(ecnt_r + 1'b1);
				if (ecnt_r == 9'(PPP_ERASE_CYC - 1)) begin
					lock_nxt = PPP_LOCK_RST;
					st_nxt   = PPP_ACTIVE;
				end
			end
			PPP_PROG: begin
				cnt_nxt = 16'(cnt_r + 1'b1);
				if (cnt_r == 16'(PPP_PROG_CYC - 1)) st_nxt = PPP_ACTIVE;
			end
			default: st_nxt = PPP_OFF;
		endcase
		if (!hv) st_nxt = PPP_OFF;
	end

	// state registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_r    <= PPP_OFF;
			cmd_r   <= PPP_CMD_NOP;
			alo_r   <= '0;
			ahi_r   <= '0;
			dlo_r   <= '0;
			dhi_r   <= '0;
			lock_r  <= PPP_LOCK_RST;
			cnt_r   <= '0;
			ecnt_r  <= '0;
			wr_en_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cmd_r   <= cmd_nxt;
			alo_r   <= alo_nxt;
			ahi_r   <= ahi_nxt;
			dlo_r   <= dlo_nxt;
			dhi_r   <= dhi_nxt;
			lock_r  <= lock_nxt;
			cnt_r   <= cnt_nxt;
			ecnt_r  <= ecnt_nxt;
			wr_en_r <= wr_en_nxt;
		end
	end

	// ------------------------------------------------------------
	// memory writes (no reset on storage)
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (st_r == PPP_ACTIVE && prise && !fo_val && cmd_r == PPP_CMD_WR_FLASH)
			pbuf[alo_r[PPP_WORD_BITS-1:0]] <= {dhi_r, dlo_r};
		if (st_r == PPP_ACTIVE && prise && !fo_val && cmd_r == PPP_CMD_WR_EE)
			eeprom[{ahi_r[0], alo_r}] <= dlo_r;
		if (st_r == PPP_PROG && cnt_r < 16'(PPP_PAGE_WORDS))
			flash[{addr[PPP_ADDR_BITS-1:PPP_WORD_BITS], cnt_r[PPP_WORD_BITS-1:0]}]
				<= pbuf[cnt_r[PPP_WORD_BITS-1:0]];
		if (st_r == PPP_ERASE) begin
			for (int i = 0; i < 32; i++)
				flash[{ecnt_r[7:0], i[4:0]}] <= 16'hFFFF;
			if (!KEEP_EEPROM_FUSE)
				for (int j = 0; j < 2; j++)
					eeprom[{ecnt_r[7:0], j[0]}] <= 8'hFF;
		end
	end

	// ------------------------------------------------------------
	// read path and outputs
	// ------------------------------------------------------------
	logic [7:0] rd_r, rd_nxt;
	logic       oe_r, oe_nxt;
	always_comb begin
		case (cmd_r)
			PPP_CMD_RD_FLASH: rd_nxt = s2_r[2] ? flash[addr][15:8] : flash[addr][7:0];
			PPP_CMD_RD_EE:    rd_nxt = eeprom[{ahi_r[0], alo_r}];
			PPP_CMD_RD_FUSE:  rd_nxt = s2_r[2] ? lock_r : 8'hFF;
			PPP_CMD_RD_SIG:   rd_nxt = 8'h00;               // arbitrary identity value
			default:          rd_nxt = 8'h00;
		endcase
		oe_nxt = !LNK.out_en_n && st_r != PPP_OFF && st_r != PPP_SETTLE;
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rd_r <= '0;
			oe_r <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign LNK.data_dev_o  = rd_r;
	assign LNK.data_dev_oe = oe_r && !LNK.out_en_n;
	assign LNK.done_flag   = !(st_r == PPP_ERASE || st_r == PPP_PROG);
	assign PROG_MODE       = st_r != PPP_OFF && st_r != PPP_SETTLE;
	assign LOCK_BITS       = lock_r;
endmodule // ppp_dev

// *** pkg/ppp_pkg.sv ***
package ppp_pkg;

	// ----------------------------------------------------------------
	// action select coding
	// ----------------------------------------------------------------
	localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
	localparam logic [1:0] PPP_ACT_DATA = 2'h1;
	localparam logic [1:0] PPP_ACT_CMD  = 2'h2;
	localparam logic [1:0] PPP_ACT_IDLE = 2'h3;

	// ----------------------------------------------------------------
	// command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] PPP_CMD_NOP      = 8'h00;
	localparam logic [7:0] PPP_CMD_ERASE    = 8'h80;
	localparam logic [7:0] PPP_CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] PPP_CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] PPP_CMD_WR_EE    = 8'h11;
	localparam logic [7:0] PPP_CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] PPP_CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] PPP_CMD_RD_EE    = 8'h03;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int PPP_WORD_BITS  = 6;               // words per page = 64
	localparam int PPP_PAGE_WORDS = 1 << PPP_WORD_BITS;
	localparam int PPP_ADDR_BITS  = 13;              // flash word address
	localparam int PPP_FLASH_WORDS = 1 << PPP_ADDR_BITS;
	localparam int PPP_EE_BYTES   = 512;
	localparam logic [7:0] PPP_LOCK_RST = 8'hFF;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PPP_CLK_NS       = 8;
	localparam int PPP_TOGGLES_MIN  = 6;
	localparam int PPP_SETUP_NS     = 100;
	localparam int PPP_SETUP_CYC    = (PPP_SETUP_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_QUIET_NS     = 100;
	localparam int PPP_QUIET_CYC    = (PPP_QUIET_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_ENTRY_US     = 50;
	localparam int PPP_ENTRY_CYC    = (PPP_ENTRY_US * 1000 + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_PULSE_NS     = 250;
	localparam int PPP_PULSE_CYC    = (PPP_PULSE_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_PROG_CYC     = 64;            // array write time
	localparam int PPP_ERASE_CYC    = 256;           // array erase time
	localparam int PPP_FIFO_DEPTH   = 8;

endpackage

// *** pkg/ppp_if.sv ***
`timescale 1ns/10ps
interface ppp_if;
	logic       hv_reset;          // reset pin at programming voltage
	logic       reset_low;         // reset pin held low
	logic       load_clock_pin;
	logic       action_select_low;
	logic       action_select_high;
	logic       half_select;
	logic       write_n;
	logic       out_en_n;
	logic       done_flag;
	logic [7:0] data_host_o;
	logic       data_host_oe;
	logic [7:0] data_dev_o;
	logic       data_dev_oe;
	wire  [7:0] data_bus = data_dev_oe ? data_dev_o : data_host_o;

	modport dev (input hv_reset, reset_low, load_clock_pin, action_select_low,
		action_select_high, half_select, write_n, out_en_n, data_bus,
		output done_flag, data_dev_o, data_dev_oe);
	modport host (output hv_reset, reset_low, load_clock_pin, action_select_low,
		action_select_high, half_select, write_n, out_en_n, data_host_o, data_host_oe,
		input done_flag, data_bus);
endinterface

// *** rtl/ppp_fifo.sv ***
`timescale 1ns/10ps
module ppp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// handshake and pointer next values
	always_comb begin
		in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
		out_valid = (cnt_r != '0);
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wp_nxt    = push ? AW'(wp_r + 1'b1) : wp_r;
		rp_nxt    = pop ? AW'(rp_r + 1'b1) : rp_r;
		cnt_nxt   = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		out_data  = mem[rp_r];
	end

	// pointer registers and storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			if (push) begin
				mem[wp_r] <= in_data;
			end
		end
	end
endmodule // ppp_fifo

// *** rtl/ppp_host.sv ***
`timescale 1ns/10ps
module ppp_host
	import ppp_pkg::*;
(
	// clock and reset
	input  wire logic       MCLK,
	input  wire logic       RST,
	// link
	ppp_if.host             LNK,
	// user request
	input  wire logic       REQ_VALID,
	output logic            REQ_READY,
	input  wire logic [2:0] REQ_KIND,   // 0 cmd,1 addr,2 data,3 latch,4 write,5 enter
	input  wire logic       REQ_HALF,
	input  wire logic [7:0] REQ_DATA,
	// read back
	output logic [7:0]      RD_DATA
);
	typedef enum {PH_RESET, PH_TOGGLE, PH_SETUP, PH_ENTRY, PH_IDLE, PH_HI, PH_LO,
		PH_WAIT} ppp_ph_state_t;

	ppp_ph_state_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0]  kind_r, kind_nxt;
	logic        half_r, half_nxt;
	logic [7:0]  dat_r, dat_nxt, rd_r, rd_nxt;
	logic [3:0]  tog_r, tog_nxt;

	// next-state logic
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = 16'(cnt_r + 1'b1);
		kind_nxt = kind_r;
		half_nxt = half_r;
		dat_nxt  = dat_r;
		rd_nxt   = LNK.data_bus;
		tog_nxt  = tog_r;
		case (st_r)
			PH_RESET: if (REQ_VALID && REQ_KIND == 3'd5) begin
				st_nxt = PH_TOGGLE; cnt_nxt = '0; tog_nxt = '0;
			end
			PH_TOGGLE: if (cnt_r == 16'(PPP_PULSE_CYC)) begin
				cnt_nxt = '0;
				tog_nxt = 4'(tog_r + 1'b1);
				if (tog_r == 4'(2 * PPP_TOGGLES_MIN - 1)) st_nxt = PH_SETUP;
			end
			PH_SETUP: if (cnt_r == 16'(PPP_SETUP_CYC)) begin
				st_nxt = PH_ENTRY; cnt_nxt = '0;
			end
			PH_ENTRY: if (cnt_r == 16'(PPP_ENTRY_CYC)) st_nxt = PH_IDLE;
			PH_IDLE: if (REQ_VALID && LNK.done_flag) begin
				kind_nxt = REQ_KIND; half_nxt = REQ_HALF; dat_nxt = REQ_DATA;
				st_nxt = PH_HI; cnt_nxt = '0;
			end
			PH_HI: if (cnt_r == 16'(PPP_PULSE_CYC)) begin
				st_nxt = PH_LO; cnt_nxt = '0;
			end
			PH_LO: if (cnt_r == 16'(PPP_PULSE_CYC)) begin
				st_nxt = PH_WAIT; cnt_nxt = '0;
			end
			PH_WAIT: if (cnt_r == 16'(PPP_PULSE_CYC)) st_nxt = PH_IDLE;
			default: st_nxt = PH_RESET;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_r   <= PH_RESET;
			cnt_r  <= '0;
			kind_r <= '0;
			half_r <= 1'b0;
			dat_r  <= '0;
			rd_r   <= '0;
			tog_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			kind_r <= kind_nxt;
			half_r <= half_nxt;
			dat_r  <= dat_nxt;
			rd_r   <= rd_nxt;
			tog_r  <= tog_nxt;
		end
	end

	// pin drive
	logic act;
	assign act = st_r == PH_HI || st_r == PH_LO;
	always_comb begin
		LNK.reset_low          = st_r == PH_TOGGLE || st_r == PH_SETUP;
		LNK.hv_reset           = st_r >= PH_ENTRY;
		LNK.load_clock_pin     = (st_r == PH_TOGGLE && tog_r[0]) ||
			(st_r == PH_HI && kind_r <= 3'd2);
		LNK.action_select_high = act && kind_r <= 3'd2 ? kind_r == 3'd0 : 1'b0;
		LNK.action_select_low  = act && kind_r == 3'd2;
		LNK.half_select        = act && (half_r || kind_r == 3'd3) &&
			!(kind_r == 3'd3 && st_r == PH_LO);         // page latch pulse
		// entry pattern keeps the write strobe low through setup and entry
		LNK.write_n            = !((st_r == PH_HI && kind_r == 3'd4) ||
			st_r == PH_SETUP || st_r == PH_ENTRY);
		LNK.out_en_n           = !(st_r == PH_IDLE && !REQ_VALID);
		LNK.data_host_o        = dat_r;
		LNK.data_host_oe       = act;
	end
	assign REQ_READY = (st_r == PH_IDLE && LNK.done_flag) || (st_r == PH_RESET && REQ_KIND == 3'd5);
	assign RD_DATA   = rd_r;
endmodule // ppp_host

// *** verif/ppp_link_asserts.sv ***
`timescale 1ns/10ps
module ppp_chk
	import ppp_pkg::*;
(
	// clock and reset
	input wire logic       MCLK,
	input wire logic       RST,
	// link signals
	input wire logic       hv_reset,
	input wire logic       reset_low,
	input wire logic       load_clock_pin,
	input wire logic       action_select_low,
	input wire logic       action_select_high,
	input wire logic       half_select,
	input wire logic       write_n,
	input wire logic       out_en_n,
	input wire logic       done_flag,
	input wire logic       data_dev_oe,
	input wire logic [7:0] data_bus
);
	localparam int ER_LO = 250;
	localparam int ER_HI = 262;
	localparam int PG_LO = 60;
	localparam int PG_HI = 68;
	logic [7:0]  cmd_r;
	logic [15:0] hv_r;
	logic [15:0] bsy_r;
	logic [3:0]  tog_r;
	logic        lck_r;
	wire         lck_rise = load_clock_pin && !lck_r;

	// last command, toggle count, time in mode, busy length
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cmd_r <= PPP_CMD_NOP;
			hv_r  <= 16'h0;
			bsy_r <= 16'h0;
			tog_r <= 4'h0;
			lck_r <= 1'b0;
		end else begin
			lck_r <= load_clock_pin;
			if (lck_rise && hv_reset && {action_select_high, action_select_low} == PPP_ACT_CMD) begin
				cmd_r <= data_bus;
			end
			hv_r  <= !hv_reset ? 16'h0 : (hv_r == 16'hFFFF ? hv_r : hv_r + 16'h1);
			bsy_r <= done_flag ? 16'h0 : bsy_r + 16'h1;
			if (lck_rise && reset_low && tog_r != 4'hF) begin
				tog_r <= tog_r + 4'h1;
			end
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	// write strobe start and end of busy
	sequence s_wr_start;
		$fell(write_n) && hv_reset;
	endsequence
	sequence s_busy_end;
		$rose(done_flag);
	endsequence

	a_erase_goes_busy: assert property (s_wr_start ##0 cmd_r == PPP_CMD_ERASE |-> ##3 !done_flag)
		else $error("erase strobe did not drop ready");
	a_erase_busy_len: assert property (s_busy_end ##0 cmd_r == PPP_CMD_ERASE |-> bsy_r inside {[ER_LO:ER_HI]})
		else $error("erase busy length wrong");
	a_page_goes_busy: assert property (s_wr_start ##0 cmd_r == PPP_CMD_WR_FLASH |-> ##3 !done_flag)
		else $error("page strobe did not drop ready");
	a_page_busy_len: assert property (s_busy_end ##0 cmd_r == PPP_CMD_WR_FLASH |-> bsy_r inside {[PG_LO:PG_HI]})
		else $error("page busy length wrong");
	a_bus_drive_gate: assert property (data_dev_oe |-> !out_en_n)
		else $error("data driven without output enable");
	a_entry_pins_still: assert property ($rose(hv_reset) |-> ({half_select, action_select_high, action_select_low, write_n} == 4'h0) [*8])
		else $error("entry pins moved after high voltage");
	a_entry_toggles: assert property ($rose(hv_reset) |-> tog_r >= 4'h6)
		else $error("too few load clock toggles");
	a_entry_wait: assert property (lck_rise && hv_reset |-> hv_r >= PPP_ENTRY_CYC)
		else $error("load before entry wait elapsed");
	a_load_when_ready: assert property (lck_rise && hv_reset |-> done_flag)
		else $error("load while busy");
endmodule // ppp_chk

// *** verif/tb_parallel_programming_port.sv ***
`timescale 1ns/10ps
module tb_parallel_programming_port;
	import ppp_pkg::*;
	logic       MCLK = 1'b0;
	logic       RST  = 1'b1;
	logic       req_valid = 1'b0;
	logic [2:0] req_kind  = 3'h0;
	logic       req_half  = 1'b0;
	logic [7:0] req_data  = 8'h00;
	logic       req_ready;
	logic [7:0] rd_data;
	logic       prog_mode;
	logic       prog_mode_b;
	logic [7:0] lock_bits;
	logic       keep_fuse = 1'b0;
	int         miscompares = 0;
	int         samples_checked = 0;

	ppp_if lnk();
	ppp_if lnk_b();
	ppp_dev ppp_dev_inst (.MCLK(MCLK), .RST(RST), .LNK(lnk), .KEEP_EEPROM_FUSE(keep_fuse),
		.PROG_MODE(prog_mode), .LOCK_BITS(lock_bits));
	ppp_host ppp_host_inst (.MCLK(MCLK), .RST(RST), .LNK(lnk), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_HALF(req_half),
		.REQ_DATA(req_data), .RD_DATA(rd_data));
	// second device driven by a rule-breaking bench driver
	ppp_dev ppp_dev_inst_b (.MCLK(MCLK), .RST(RST), .LNK(lnk_b), .KEEP_EEPROM_FUSE(1'b1),
		.PROG_MODE(prog_mode_b), .LOCK_BITS());
	ppp_chk ppp_chk_inst (.MCLK(MCLK), .RST(RST), .hv_reset(lnk.hv_reset),
		.reset_low(lnk.reset_low), .load_clock_pin(lnk.load_clock_pin),
		.action_select_low(lnk.action_select_low), .action_select_high(lnk.action_select_high),
		.half_select(lnk.half_select), .write_n(lnk.write_n), .out_en_n(lnk.out_en_n),
		.done_flag(lnk.done_flag), .data_dev_oe(lnk.data_dev_oe), .data_bus(lnk.data_bus));

	// 125 MHz clock
	always #4 MCLK = ~MCLK;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one user request through the valid/ready handshake
	task automatic req(input logic [2:0] k, input logic h, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge MCLK);
		req_valid = 1'b1;
		req_kind  = k;
		req_half  = h;
		req_data  = d;
		#1;
		while (req_ready !== 1'b1 && n < 20000) begin
			@(negedge MCLK);
			#1;
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
			$display("ERROR %0t request not taken", $time);
		end
		@(posedge MCLK);
		@(negedge MCLK);
		req_valid = 1'b0;
	endtask

	// busy length in cycles, lock bits seen at start of busy
	task automatic busy(output int n, output logic [7:0] m);
		int w;
		w = 0;
		n = 0;
		while (lnk.done_flag !== 1'b0 && w < 400) begin
			@(negedge MCLK);
			w++;
		end
		m = lock_bits;
		while (lnk.done_flag === 1'b0 && n < 2000) begin
			@(negedge MCLK);
			n++;
		end
	endtask

	// entry pins moved inside the quiet span
	task automatic t_refuse;
		repeat (8) begin
			repeat (40) @(negedge MCLK);
			lnk_b.load_clock_pin = ~lnk_b.load_clock_pin;
		end
		lnk_b.write_n = 1'b0;
		repeat (20) @(negedge MCLK);
		lnk_b.hv_reset  = 1'b1;
		lnk_b.reset_low = 1'b0;
		repeat (4) @(negedge MCLK);
		lnk_b.action_select_low = 1'b1;
		repeat (60) @(negedge MCLK);
		check({15'h0, prog_mode_b}, 16'h0);
	endtask

	task automatic t_enter;
		req(3'h5, 1'b0, 8'h00);
		repeat (600) @(negedge MCLK);
		check({15'h0, prog_mode}, 16'h1);
		check({15'h0, lnk.done_flag}, 16'h1);
		check({15'h0, lnk.data_dev_oe}, 16'h0);
	endtask

	// lock write, then erase releases lock only at its end
	task automatic t_lock_erase;
		int         n;
		logic [7:0] m;
		req(3'h0, 1'b0, PPP_CMD_WR_LOCK);
		req(3'h2, 1'b0, 8'h00);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		check({8'h0, lock_bits}, 16'h0000);
		req(3'h0, 1'b0, PPP_CMD_ERASE);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		check({8'h0, m}, 16'h0000);
		check({8'h0, lock_bits}, 16'h00FF);
		check({15'h0, n inside {[250:262]}}, 16'h1);
	endtask

	// keep-eeprom fuse spares eeprom, cleared fuse lets erase wipe it
	task automatic t_keep;
		int         n;
		logic [7:0] m;
		keep_fuse = 1'b1;
		req(3'h0, 1'b0, PPP_CMD_WR_EE);
		req(3'h1, 1'b0, 8'h05);
		req(3'h2, 1'b0, 8'h5A);
		req(3'h3, 1'b1, 8'h00);
		req(3'h0, 1'b0, PPP_CMD_ERASE);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		req(3'h0, 1'b0, PPP_CMD_RD_EE);
		repeat (120) @(negedge MCLK);
		check({8'h0, rd_data}, 16'h005A);
		keep_fuse = 1'b0;
		req(3'h0, 1'b0, PPP_CMD_ERASE);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		req(3'h0, 1'b0, PPP_CMD_RD_EE);
		repeat (120) @(negedge MCLK);
		check({8'h0, rd_data}, 16'h00FF);
	endtask

	// load cnt words of a page word by word through the buffer
	task automatic load_words(input logic [7:0] base, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			req(3'h1, 1'b0, base + 8'(i));
			req(3'h2, 1'b0, 8'(i));
			req(3'h2, 1'b1, ~8'(i));
			req(3'h4 - 3'h1, 1'b1, 8'h00);
		end
	endtask

	task automatic t_page;
		int         n;
		logic [7:0] m;
		req(3'h0, 1'b0, PPP_CMD_WR_FLASH);
		load_words(8'h40, 9);
		req(3'h1, 1'b1, 8'h00);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		check({15'h0, n inside {[60:68]}}, 16'h1);
		// second page with the command left in place
		load_words(8'h80, 2);
		req(3'h1, 1'b1, 8'h01);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		check({15'h0, n inside {[60:68]}}, 16'h1);
		// no-op clears the write control, strobe does nothing
		req(3'h0, 1'b0, PPP_CMD_NOP);
		req(3'h4, 1'b0, 8'h00);
		busy(n, m);
		check(16'(n), 16'h0000);
		// page word read back through the low byte
		req(3'h0, 1'b0, PPP_CMD_RD_FLASH);
		req(3'h1, 1'b1, 8'h00);
		req(3'h1, 1'b0, 8'h43);
		repeat (120) @(negedge MCLK);
		check({8'h0, rd_data}, 16'h0003);
	endtask

	// main sequence
	initial begin
		lnk_b.hv_reset           = 1'b0;
		lnk_b.reset_low          = 1'b1;
		lnk_b.load_clock_pin     = 1'b0;
		lnk_b.action_select_low  = 1'b0;
		lnk_b.action_select_high = 1'b0;
		lnk_b.half_select        = 1'b0;
		lnk_b.write_n            = 1'b1;
		lnk_b.out_en_n           = 1'b1;
		lnk_b.data_host_o        = 8'h00;
		lnk_b.data_host_oe       = 1'b0;
		repeat (12) @(negedge MCLK);
		RST = 1'b0;
		t_refuse();
		t_enter();
		t_lock_erase();
		t_keep();
		t_page();
		tally_and_finish();
	end

	// watchdog
	initial begin
		#400000;
		miscompares++;
		tally_and_finish();
	end
endmodule // tb_parallel_programming_port
